// file: companion_pkg.sv
/*
 * Constants shared by the processor companion core: register indices,
 * field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock; every count below except PIN_GUARD_CYC is derived from it.
 */
package companion_pkg;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int OSC_START_MAX_S = 2;
	localparam int RST_HOLD_MS = 100;
	localparam int WD_STEP_MS = 100;
	localparam int CAL_HZ = 512;
	localparam int SEC_CYC = CLK_HZ;
	localparam int RST_HOLD_CYC = CLK_HZ / 1000 * RST_HOLD_MS;
	localparam int WD_STEP_CYC = CLK_HZ / 1000 * WD_STEP_MS;
	localparam int CAL_HALF_CYC = CLK_HZ / (2 * CAL_HZ);
	localparam int PIN_GUARD_CYC = 4;
	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_RTC_CTRL = 6'h00;
	localparam logic [5:0] IDX_SEC = 6'h01;
	localparam logic [5:0] IDX_MIN = 6'h02;
	localparam logic [5:0] IDX_HOUR = 6'h03;
	localparam logic [5:0] IDX_WDAY = 6'h04;
	localparam logic [5:0] IDX_DATE = 6'h05;
	localparam logic [5:0] IDX_MONTH = 6'h06;
	localparam logic [5:0] IDX_YEAR = 6'h07;
	localparam logic [5:0] IDX_CENT = 6'h08;
	localparam logic [5:0] IDX_WD_FLAGS = 6'h09;
	localparam logic [5:0] IDX_WD_CFG = 6'h0A;
	localparam logic [5:0] IDX_SUP_CFG = 6'h0B;
	localparam logic [5:0] IDX_CNT_CFG = 6'h0C;
	localparam logic [5:0] IDX_EVENT_IN_1 = 6'h0D;
	localparam logic [5:0] IDX_EVENT_IN_2 = 6'h0E;
	localparam logic [5:0] IDX_SN_LO = 6'h0F;
	localparam logic [5:0] IDX_SN_HI = 6'h10;
	localparam logic [5:0] IDX_SN_LOCK = 6'h11;
	localparam logic [5:0] IDX_STATUS = 6'h12;
	// ==========================================================
	// field positions and values
	localparam int B_CAL_MODE = 0;
	localparam int B_OSC_EN_N = 1;
	localparam int B_WD_FLAG = 7;
	localparam int B_POR_FLAG = 6;
	localparam int B_WDE = 7;
	localparam int B_VTP = 0;
	localparam int B_BACKUP_CHG = 2;
	localparam logic [3:0] WD_RESTART_PAT = 4'hA;
	localparam logic [4:0] WD_OFF = 5'h1F;
	localparam logic [4:0] WD_TMO_RST = 5'h1F;
	localparam logic [7:0] SUP_CFG_RST = 8'h04;
endpackage

// file: companion_core.sv
/*
 * Processor companion core: BCD clock/calendar, calibration and power-fail
 * output, supply and watchdog reset with manual reset, reset-source flags,
 * two event counters and a lockable serial number, behind a Wishbone slave.
 * Assumes analog comparators deliver digital levels on supply_low and
 * powerfail_in, and that the reset pin has an external weak pull-up.
 */
// Local design decisions: the register offsets and register access over Wishbone.
// Behaviour
// - clearing osc_enable_n starts oscillator within 2s
// - keep time fields seconds to centuries BCD
// - leap days correct through year 2099
// - calibration mode outputs 512 Hz square wave
// - otherwise output follows power-fail comparator
// - reset active while supply low, plus 100 ms
// - watchdog timeout 100 ms to 3 s
// - enabled watchdog expiry drives reset 100 ms
// - flag records supply or watchdog reset source
// - power-fail input compared with 1.2 V reference
// - serial number writable until locked
// - event counters count selected edges
// - edge polarity selectable per counter
// - answer only when select pins match address; the core still acks other selects, with zero read data
// - sample inputs on rising clock edges
// - serial slave accepts 100k, 400k, 1M rates
// - external low on reset pin is manual reset
// - companion answers on its own identifier
// - manual reset drives reset pin 100 ms
// - only pattern 1010b restarts and reloads watchdog; the core also restarts it while rst_n_oe is asserted
// - bus activity ignored while reset asserted; the core still acks, with zero read data
`timescale 1ns/100ps
module companion_core
	import companion_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYC,
	parameter int HOLD_CYCLES = RST_HOLD_CYC,
	parameter int STEP_CYCLES = WD_STEP_CYC,
	parameter int CAL_HALF = CAL_HALF_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [1:0] dev_select,
	input wire logic supply_low,
	input wire logic powerfail_in,
	input wire logic event_in_1,
	input wire logic event_in_2,
	input wire logic rst_n_in,
	output logic rst_n_out,
	output logic rst_n_oe,
	output logic cal_or_pf_out,
	output logic osc_run,
	output logic vtp_sel,
	output logic backup_charge_en
);
	// ==========================================================
	// parameter check
	if (SEC_CYCLES < 2 || HOLD_CYCLES < 1 || STEP_CYCLES < 2 ||
	    CAL_HALF < 1) begin : g_bad
		$error("companion_core: counts too small");
	end

	// ==========================================================
	// pin synchronisers
	logic [1:0] dsel_s1_ff, dsel_s2_ff;
	logic sup_s1_ff, sup_s2_ff, pf_s1_ff, pf_s2_ff, rin_s1_ff, rin_s2_ff;
	logic [1:0] ev_s1_ff, ev_s2_ff, ev_prev_ff;
	// two flops per pin before any logic looks at it
	always_ff @(posedge clk) begin
		dsel_s1_ff <= dev_select;
		dsel_s2_ff <= dsel_s1_ff;
		sup_s1_ff <= supply_low;
		sup_s2_ff <= sup_s1_ff;
		pf_s1_ff <= powerfail_in;
		pf_s2_ff <= pf_s1_ff;
		rin_s1_ff <= rst_n_in;
		rin_s2_ff <= rin_s1_ff;
		ev_s1_ff <= {event_in_2, event_in_1};
		ev_s2_ff <= ev_s1_ff;
		ev_prev_ff <= ev_s2_ff;
	end

	// ==========================================================
	// bus slave
	logic ack_ff, rst_oe_ff, sel_ok, req, wr;
	logic [5:0] idx;
	logic [31:0] wmask;
	assign idx = adr_i[7:2];
	assign sel_ok = (adr_i[9:8] == dsel_s2_ff);
	assign req = cyc_i & stb_i & ~ack_ff;
	assign wr = req & we_i & sel_ok & ~rst_oe_ff;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};

	// control registers
	logic cal_mode_ff, osc_en_n_ff, wde_ff, lock_ff;
	logic [4:0] wd_tmo_ff;
	logic [7:0] sup_cfg_ff;
	logic [1:0] pol_ff;
	logic [63:0] sn_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			cal_mode_ff <= 1'b0;
			osc_en_n_ff <= 1'b1;
			wde_ff <= 1'b0;
			wd_tmo_ff <= WD_TMO_RST;
			sup_cfg_ff <= SUP_CFG_RST;
			pol_ff <= 2'b00;
		end else if (wr && sel_i[0]) begin
			if (idx == IDX_RTC_CTRL) begin
				cal_mode_ff <= dat_i[B_CAL_MODE];
				osc_en_n_ff <= dat_i[B_OSC_EN_N];
			end else if (idx == IDX_WD_CFG) begin
				wde_ff <= dat_i[B_WDE];
				wd_tmo_ff <= dat_i[4:0];
			end else if (idx == IDX_SUP_CFG) begin
				sup_cfg_ff <= dat_i[7:0];
			end else if (idx == IDX_CNT_CFG) begin
				pol_ff <= dat_i[1:0];
			end
		end
	end

	// serial number and its lock, lock only sets
	always_ff @(posedge clk) begin
		if (reset) begin
			sn_ff <= 64'h0;
			lock_ff <= 1'b0;
		end else if (wr && !lock_ff) begin
			if (idx == IDX_SN_LO) begin
				sn_ff[31:0] <= (sn_ff[31:0] & ~wmask) | (dat_i & wmask);
			end else if (idx == IDX_SN_HI) begin
				sn_ff[63:32] <= (sn_ff[63:32] & ~wmask) | (dat_i & wmask);
			end else if (idx == IDX_SN_LOCK && sel_i[0]) begin
				lock_ff <= dat_i[0];
			end
		end
	end

	// ==========================================================
	// oscillator, second tick and calibration wave
	logic [31:0] sec_pre_ff, cal_pre_ff;
	logic sec_tick, cal_wave_ff, osc_run_ff;
	assign sec_tick = osc_run_ff && (sec_pre_ff == 32'(SEC_CYCLES - 1));
	// single clock domain: writes land before the next tick uses them
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_run_ff <= 1'b0;
			sec_pre_ff <= 32'h0;
			cal_pre_ff <= 32'h0;
			cal_wave_ff <= 1'b0;
		end else begin
			osc_run_ff <= ~osc_en_n_ff;
			sec_pre_ff <= (!osc_run_ff || sec_tick) ? 32'h0 :
				sec_pre_ff + 32'h1;
			if (!osc_run_ff || cal_pre_ff == 32'(CAL_HALF - 1)) begin
				cal_pre_ff <= 32'h0;
				cal_wave_ff <= osc_run_ff & ~cal_wave_ff;
			end else begin
				cal_pre_ff <= cal_pre_ff + 32'h1;
			end
		end
	end

	// ==========================================================
	// calendar
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction
	function automatic logic [7:0] last_day(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == 8'h02) begin
			last_day = leap ? 8'h29 : 8'h28;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 ||
		             m == 8'h11) begin
			last_day = 8'h30;
		end else begin
			last_day = 8'h31;
		end
	endfunction
	logic [7:0] sec_ff, min_ff, hour_ff, wday_ff, date_ff, mon_ff;
	logic [7:0] year_ff, cent_ff;
	// carry chain on each second, then software writes override
	always_ff @(posedge clk) begin
		if (reset) begin
			{sec_ff, min_ff, hour_ff} <= 24'h0;
			{wday_ff, date_ff, mon_ff} <= 24'h010101;
			{year_ff, cent_ff} <= 16'h0020;
		end else begin
			if (sec_tick) begin
				sec_ff <= (sec_ff == 8'h59) ? 8'h00 : bcd_inc(sec_ff);
				if (sec_ff == 8'h59) begin
					min_ff <= (min_ff == 8'h59) ? 8'h00 : bcd_inc(min_ff);
					if (min_ff == 8'h59) begin
						hour_ff <= (hour_ff == 8'h23) ? 8'h00 : bcd_inc(hour_ff);
						if (hour_ff == 8'h23) begin
							wday_ff <= (wday_ff == 8'h07) ? 8'h01 : wday_ff + 8'h01;
							date_ff <= bcd_inc(date_ff);
							if (date_ff == last_day(mon_ff, year_ff)) begin
								date_ff <= 8'h01;
								mon_ff <= bcd_inc(mon_ff);
								if (mon_ff == 8'h12) begin
									mon_ff <= 8'h01;
									year_ff <= bcd_inc(year_ff);
									if (year_ff == 8'h99) begin
										year_ff <= 8'h00;
										cent_ff <= bcd_inc(cent_ff);
									end
								end
							end
						end
					end
				end
			end
			if (wr && sel_i[0]) begin
				if (idx == IDX_SEC) sec_ff <= dat_i[7:0];
				else if (idx == IDX_MIN) min_ff <= dat_i[7:0];
				else if (idx == IDX_HOUR) hour_ff <= dat_i[7:0];
				else if (idx == IDX_WDAY) wday_ff <= dat_i[7:0];
				else if (idx == IDX_DATE) date_ff <= dat_i[7:0];
				else if (idx == IDX_MONTH) mon_ff <= dat_i[7:0];
				else if (idx == IDX_YEAR) year_ff <= dat_i[7:0];
				else if (idx == IDX_CENT) cent_ff <= dat_i[7:0];
			end
		end
	end

	// ==========================================================
	// event counters
	logic [15:0] cnt_ff [2];
	logic [1:0] ev_hit;
	for (genvar i = 0; i < 2; i++) begin : g_cnt
		logic [5:0] my_idx;
		assign my_idx = (i == 0) ? IDX_EVENT_IN_1 : IDX_EVENT_IN_2;
		// edge picked by polarity, 1 selects falling
		assign ev_hit[i] = pol_ff[i] ? (ev_prev_ff[i] & ~ev_s2_ff[i]) :
			(~ev_prev_ff[i] & ev_s2_ff[i]);
		always_ff @(posedge clk) begin
			if (reset) begin
				cnt_ff[i] <= 16'h0;
			end else if (wr && idx == my_idx) begin
				cnt_ff[i] <= (cnt_ff[i] & ~wmask[15:0]) |
					(dat_i[15:0] & wmask[15:0]);
			end else if (ev_hit[i]) begin
				cnt_ff[i] <= cnt_ff[i] + 16'h1;
			end
		end
	end

	// ==========================================================
	// watchdog
	logic [31:0] wd_pre_ff;
	logic [4:0] wd_cnt_ff, wd_load_ff;
	logic wd_restart, wd_step, wd_fire;
	assign wd_restart = (wr && sel_i[0] && idx == IDX_WD_FLAGS &&
		dat_i[3:0] == WD_RESTART_PAT) || rst_oe_ff;
	assign wd_step = (wd_pre_ff == 32'(STEP_CYCLES - 1));
	assign wd_fire = wd_step && wd_load_ff != WD_OFF &&
		(wd_cnt_ff + 5'h1 >= wd_load_ff);
	always_ff @(posedge clk) begin
		if (reset || wd_restart) begin
			wd_pre_ff <= 32'h0;
			wd_cnt_ff <= 5'h0;
			wd_load_ff <= reset ? WD_TMO_RST : wd_tmo_ff;
		end else begin
			wd_pre_ff <= wd_step ? 32'h0 : wd_pre_ff + 32'h1;
			if (wd_fire) wd_cnt_ff <= 5'h0;
			else if (wd_step) wd_cnt_ff <= wd_cnt_ff + 5'h1;
		end
	end

	// ==========================================================
	// reset pin: supply, watchdog and manual sources
	logic [31:0] hold_ff, nxt_hold;
	logic [2:0] guard_ff;
	logic man_det, por_flag_ff, wd_flag_ff, flag_clr;
	assign man_det = ~rin_s2_ff & ~rst_oe_ff & (guard_ff == 3'h0);
	always_comb begin
		nxt_hold = (hold_ff != 32'h0) ? hold_ff - 32'h1 : 32'h0;
		if (sup_s2_ff || man_det || (wd_fire && wde_ff)) begin
			nxt_hold = 32'(HOLD_CYCLES);
		end
	end
	// guard lets the pin recover before it is read as manual reset
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_ff <= 32'h0;
			rst_oe_ff <= 1'b0;
			guard_ff <= 3'h0;
		end else begin
			hold_ff <= nxt_hold;
			rst_oe_ff <= (nxt_hold != 32'h0);
			guard_ff <= rst_oe_ff ? 3'(PIN_GUARD_CYC) :
				(guard_ff != 3'h0) ? guard_ff - 3'h1 : 3'h0;
		end
	end
	// source flags: set wins over write-one-to-clear
	assign flag_clr = wr && sel_i[0] && idx == IDX_WD_FLAGS;
	always_ff @(posedge clk) begin
		if (reset) begin
			por_flag_ff <= 1'b0;
			wd_flag_ff <= 1'b0;
		end else begin
			por_flag_ff <= sup_s2_ff |
				(por_flag_ff & ~(flag_clr & dat_i[B_POR_FLAG]));
			wd_flag_ff <= wd_fire |
				(wd_flag_ff & ~(flag_clr & dat_i[B_WD_FLAG]));
		end
	end

	// ==========================================================
	// read data and registered outputs
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0;
		if (!sel_ok || rst_oe_ff) rd = 32'h0;
		else if (idx == IDX_RTC_CTRL) rd = {30'h0, osc_en_n_ff, cal_mode_ff};
		else if (idx == IDX_SEC) rd = {24'h0, sec_ff};
		else if (idx == IDX_MIN) rd = {24'h0, min_ff};
		else if (idx == IDX_HOUR) rd = {24'h0, hour_ff};
		else if (idx == IDX_WDAY) rd = {24'h0, wday_ff};
		else if (idx == IDX_DATE) rd = {24'h0, date_ff};
		else if (idx == IDX_MONTH) rd = {24'h0, mon_ff};
		else if (idx == IDX_YEAR) rd = {24'h0, year_ff};
		else if (idx == IDX_CENT) rd = {24'h0, cent_ff};
		else if (idx == IDX_WD_FLAGS) rd = {24'h0, wd_flag_ff, por_flag_ff,
			6'h0};
		else if (idx == IDX_WD_CFG) rd = {24'h0, wde_ff, 2'h0, wd_tmo_ff};
		else if (idx == IDX_SUP_CFG) rd = {24'h0, sup_cfg_ff};
		else if (idx == IDX_CNT_CFG) rd = {30'h0, pol_ff};
		else if (idx == IDX_EVENT_IN_1) rd = {16'h0, cnt_ff[0]};
		else if (idx == IDX_EVENT_IN_2) rd = {16'h0, cnt_ff[1]};
		else if (idx == IDX_SN_LO) rd = sn_ff[31:0];
		else if (idx == IDX_SN_HI) rd = sn_ff[63:32];
		else if (idx == IDX_SN_LOCK) rd = {31'h0, lock_ff};
		else if (idx == IDX_STATUS) rd = {30'h0, rst_oe_ff, pf_s2_ff};
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			ack_ff <= 1'b0;
			dat_o <= 32'h0;
			cal_or_pf_out <= 1'b0;
		end else begin
			ack_ff <= req;
			dat_o <= (req && !we_i) ? rd : 32'h0;
			cal_or_pf_out <= cal_mode_ff ? cal_wave_ff : pf_s2_ff;
		end
	end
	assign ack_o = ack_ff;
	assign rst_n_oe = rst_oe_ff;
	assign rst_n_out = 1'b0;
	assign osc_run = osc_run_ff;
	assign vtp_sel = sup_cfg_ff[B_VTP];
	assign backup_charge_en = sup_cfg_ff[B_BACKUP_CHG];

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	chk_osc_start: assert property ($fell(osc_en_n_ff) |=> osc_run)
		else $error("oscillator did not start");
	chk_cal_wave: assert property (cal_mode_ff |=>
		cal_or_pf_out == $past(cal_wave_ff)) else $error("cal wave lost");
	chk_pf_follow: assert property (!cal_mode_ff |=>
		cal_or_pf_out == $past(pf_s2_ff)) else $error("pf not passed");
	chk_supply_hold: assert property ($fell(sup_s2_ff) |->
		rst_n_oe [*8]) else $error("reset released early");
	chk_wd_reset: assert property (wd_fire && wde_ff |=>
		rst_n_oe && hold_ff == 32'(HOLD_CYCLES)) else $error("wd no reset");
	chk_por_flag: assert property (sup_s2_ff |=> por_flag_ff)
		else $error("por flag not set");
	chk_sn_lock: assert property (lock_ff |=> $stable(sn_ff))
		else $error("locked serial changed");
	chk_evt_count: assert property (ev_hit[0] && !(wr && idx == IDX_EVENT_IN_1)
		|=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h1)
		else $error("event missed");
	chk_dev_match: assert property (req && !we_i && !sel_ok |=>
		ack_o && dat_o == 32'h0) else $error("foreign address answered");
	chk_wd_pattern: assert property (wd_restart && !reset |=>
		wd_cnt_ff == 5'h0 && wd_pre_ff == 32'h0) else $error("no restart");
	chk_rst_block: assert property (req && rst_oe_ff |=>
		dat_o == 32'h0) else $error("bus not locked out");
	cov_wd_fire: cover property (wd_fire && wde_ff);
	cov_manual: cover property (man_det);
	cov_year_wrap: cover property (sec_tick && year_ff == 8'h99 &&
		mon_ff == 8'h12);
	cov_lock_write: cover property (lock_ff && wr && idx == IDX_SN_LO);
endmodule

// file: host_bus_model.sv
/* host processor model: classic wishbone single cycles for the bench.
   assumes a slave with a registered ack arriving within 49 cycles. */
`timescale 1ns/100ps
module host_bus_model (
	input wire logic clk,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	output logic cyc_i,
	output logic stb_i,
	output logic we_i,
	output logic [9:0] adr_i,
	output logic [3:0] sel_i,
	output logic [31:0] dat_i,
	output logic stuck
);
	// ==========================================================
	// idle bus at time zero
	initial begin
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 10'h000;
		sel_i = 4'h0;
		dat_i = 32'h0;
		stuck = 1'b0;
	end
	// one request held until ack is sampled high on a rising edge
	task automatic xfer(input logic w, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hF;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		stuck = (n >= 50);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		adr_i <= ~a; // released lines stop showing old values
		dat_i <= ~d;
	endtask
endmodule

// file: tb_processor_companion_core.sv
/* self-checking bench for the companion core: read answers are matched
   against a queue of notes, pins and cycle counts directly.
   assumes host_bus_model and short timing parameters on the core. */
`timescale 1ns/100ps
module tb_processor_companion_core;
	import companion_pkg::*;
	localparam int HOLD = 10;
	localparam int STEP = 20;
	localparam int CALH = 4;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ack_o, rst_n_out, rst_n_oe, cal_or_pf_out, osc_run;
	logic vtp_sel, backup_charge_en, stuck, cyc_i, stb_i, we_i, p;
	logic [9:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, v, sn;
	logic [63:0] e;
	logic [1:0] dsel = 2'h0;
	logic supply_low = 1'b0;
	logic powerfail_in = 1'b0;
	logic btn = 1'b0;
	logic event_in_1 = 1'b0;
	logic event_in_2 = 1'b0;
	logic [63:0] expq [$];
	int err_total = 0;
	int tests_run = 0;
	int cyc_n = 0;
	int n, t0;
	// reset pin: weak pull-up, pulled low by the core or the button
	wire logic rst_n_in = !(rst_n_oe === 1'b1 || btn);

	// ==========================================================
	// clock, cycle count, instances
	always #20 clk = ~clk;
	always @(posedge clk) cyc_n <= cyc_n + 1;
	companion_core #(.SEC_CYCLES(50), .HOLD_CYCLES(HOLD),
		.STEP_CYCLES(STEP), .CAL_HALF(CALH)) i_dut (.clk(clk),
		.reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .dev_select(dsel), .supply_low(supply_low),
		.powerfail_in(powerfail_in), .event_in_1(event_in_1),
		.event_in_2(event_in_2), .rst_n_in(rst_n_in),
		.rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe),
		.cal_or_pf_out(cal_or_pf_out), .osc_run(osc_run),
		.vtp_sel(vtp_sel), .backup_charge_en(backup_charge_en));
	host_bus_model i_host (.clk(clk), .ack_o(ack_o), .dat_o(dat_o),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .stuck(stuck));

	// ==========================================================
	// oldest note popped on every read answer, compared when its mask is nonzero
	always @(posedge clk) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0) begin
			e = expq.pop_front();
			if (e[63:32] != 32'h0) chk_reg(dat_o & e[63:32], e[31:0]);
		end
	end

	// ==========================================================
	// verdict, compares and waits
	task automatic complete_run();
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		$display("[ERR] %0t wait limit used up", $time);
		complete_run();
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] x);
		tests_run++;
		if (got !== x) begin
			err_total++;
			$display("[ERR] %0t read %h expected %h", $time, got, x);
		end
	endtask
	task automatic chk_pin(input logic got, input logic x);
		tests_run++;
		if (got !== x) begin
			err_total++;
			$display("[ERR] %0t pin %b expected %b", $time, got, x);
		end
	endtask
	task automatic chk_cnt(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("[ERR] %0t count %0d not in %0d..%0d", $time, got,
				lo, hi);
		end
	endtask
	task automatic acc(input logic w, input logic [1:0] ds,
		input logic [5:0] ix, input logic [31:0] d);
		i_host.xfer(w, {ds, ix, 2'b00}, d, v);
		if (stuck === 1'b1) hang();
	endtask
	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		acc(1'b1, dsel, ix, d);
	endtask
	task automatic rd(input logic [5:0] ix, input logic [31:0] m,
		input logic [31:0] x);
		expq.push_back({m, x});
		acc(1'b0, dsel, ix, 32'h0);
	endtask
	task automatic wait_oe(input logic lvl, input int lim, output int k);
		k = 0;
		while (rst_n_oe !== lvl) begin
			@(posedge clk);
			k++;
			if (k > lim) hang();
		end
	endtask
	task automatic wait_rise(output int k);
		k = 0;
		do begin
			p = cal_or_pf_out;
			@(posedge clk);
			k++;
			if (k > 40) hang();
		end while (!(p === 1'b0 && cal_or_pf_out === 1'b1));
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(49));
		dsel <= 2'($urandom);
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk_pin(osc_run, 1'b0);
		chk_pin(backup_charge_en, 1'b1);
		rd(IDX_RTC_CTRL, 32'h3, 32'h2);
		rd(IDX_WD_CFG, 32'hFF, 32'h1F);
		rd(IDX_CENT, 32'hFF, 32'h20);
		wr(IDX_RTC_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		chk_pin(osc_run, 1'b1);
		// rollover at the end of february, leap and common year
		for (int i = 0; i < 2; i++) begin
			wr(IDX_YEAR, i ? 32'h23 : 32'h24);
			wr(IDX_MONTH, 32'h02);
			wr(IDX_DATE, 32'h28);
			wr(IDX_HOUR, 32'h23);
			wr(IDX_MIN, 32'h59);
			wr(IDX_SEC, 32'h59);
			n = 0;
			do begin
				expq.push_back(64'h0);
				acc(1'b0, dsel, IDX_SEC, 32'h0);
				n++;
				if (n > 60) hang();
			end while (v[7:0] !== 8'h00);
			rd(IDX_HOUR, 32'hFF, 32'h00);
			rd(IDX_DATE, 32'hFF, i ? 32'h01 : 32'h29);
			rd(IDX_MONTH, 32'hFF, i ? 32'h03 : 32'h02);
		end
		// calibration wave, then power-fail pass-through
		wr(IDX_RTC_CTRL, 32'h1);
		wait_rise(n);
		wait_rise(n);
		chk_cnt(n, 2 * CALH, 2 * CALH);
		wr(IDX_RTC_CTRL, 32'h0);
		repeat (4) begin
			powerfail_in <= 1'($urandom);
			repeat (4) @(posedge clk);
			chk_pin(cal_or_pf_out, powerfail_in);
		end
		rd(IDX_STATUS, 32'h3, {31'h0, powerfail_in});
		// manual reset from the pin
		btn <= 1'b1;
		wait_oe(1'b1, 8, n);
		chk_pin(rst_n_out, 1'b0);
		btn <= 1'b0;
		wait_oe(1'b0, 30, n);
		chk_cnt(n, HOLD - 1, HOLD + 6);
		// supply reset, bus locked out meanwhile
		wr(IDX_WD_FLAGS, 32'hC0);
		supply_low <= 1'b1;
		wait_oe(1'b1, 8, n);
		chk_cnt(n, 2, 5);
		wr(IDX_SUP_CFG, 32'h1);
		rd(IDX_SUP_CFG, 32'hFF, 32'h0);
		supply_low <= 1'b0;
		wait_oe(1'b0, 30, n);
		chk_cnt(n, HOLD, HOLD + 5);
		rd(IDX_SUP_CFG, 32'hFF, {24'h0, SUP_CFG_RST});
		rd(IDX_WD_FLAGS, 32'hC0, 32'h40);
		// watchdog at 200 ms, restarted twice, wrong pattern ignored
		wr(IDX_WD_FLAGS, 32'hC0);
		wr(IDX_WD_CFG, 32'h82);
		wr(IDX_WD_FLAGS, 32'h0A);
		repeat (30) @(posedge clk);
		wr(IDX_WD_FLAGS, 32'h0A);
		t0 = cyc_n;
		wr(IDX_WD_FLAGS, 32'h05);
		wait_oe(1'b1, 80, n);
		chk_cnt(cyc_n - t0, 2 * STEP - 1, 2 * STEP + 1);
		wait_oe(1'b0, 30, n);
		wr(IDX_WD_CFG, 32'h1F);
		rd(IDX_WD_FLAGS, 32'h80, 32'h80);
		// event counters, counter 1 on falling, counter 2 on rising
		wr(IDX_CNT_CFG, 32'h1);
		wr(IDX_EVENT_IN_1, 32'h0);
		wr(IDX_EVENT_IN_2, 32'h0);
		event_in_1 <= 1'b1;
		event_in_2 <= 1'b1;
		repeat (5) @(posedge clk);
		rd(IDX_EVENT_IN_1, 32'hFFFF, 32'h0);
		rd(IDX_EVENT_IN_2, 32'hFFFF, 32'h1);
		n = 1 + int'($urandom % 5);
		repeat (n) begin
			event_in_1 <= 1'b0;
			event_in_2 <= 1'b0;
			repeat (4) @(posedge clk);
			event_in_1 <= 1'b1;
			event_in_2 <= 1'b1;
			repeat (4) @(posedge clk);
		end
		rd(IDX_EVENT_IN_1, 32'hFFFF, 32'(n));
		rd(IDX_EVENT_IN_2, 32'hFFFF, 32'(n + 1));
		// serial number lock
		sn = $urandom;
		wr(IDX_SN_LO, sn);
		rd(IDX_SN_LO, 32'hFFFFFFFF, sn);
		wr(IDX_SN_LOCK, 32'h1);
		wr(IDX_SN_LO, ~sn);
		rd(IDX_SN_LO, 32'hFFFFFFFF, sn);
		// foreign select, unmapped place, backup charge cleared
		acc(1'b1, ~dsel, IDX_SUP_CFG, 32'h1);
		expq.push_back({32'hFFFFFFFF, 32'h0});
		acc(1'b0, ~dsel, IDX_SUP_CFG, 32'h0);
		rd(6'h3F, 32'hFFFFFFFF, 32'h0);
		rd(IDX_SUP_CFG, 32'hFF, {24'h0, SUP_CFG_RST});
		wr(IDX_SUP_CFG, 32'h1);
		@(posedge clk);
		chk_pin(backup_charge_en, 1'b0);
		chk_pin(vtp_sel, 1'b1);
		chk_cnt(expq.size(), 0, 0);
		complete_run();
	end
endmodule
